// ==== hw/vtm_pkg.sv ====
`default_nettype none
package vtm_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_EXIT_CTL       = 8'h00;
  localparam logic [7:0] OFS_ENTRY_CTL      = 8'h04;
  localparam logic [7:0] OFS_EXIT_ST_CNT    = 8'h08;
  localparam logic [7:0] OFS_EXIT_ST_LO     = 8'h0C;
  localparam logic [7:0] OFS_EXIT_ST_HI     = 8'h10;
  localparam logic [7:0] OFS_EXIT_LD_CNT    = 8'h14;
  localparam logic [7:0] OFS_EXIT_LD_LO     = 8'h18;
  localparam logic [7:0] OFS_EXIT_LD_HI     = 8'h1C;
  localparam logic [7:0] OFS_ENTRY_LD_CNT   = 8'h20;
  localparam logic [7:0] OFS_ENTRY_LD_LO    = 8'h24;
  localparam logic [7:0] OFS_ENTRY_LD_HI    = 8'h28;
  localparam logic [7:0] OFS_EXIT_CAP_LO    = 8'h2C;
  localparam logic [7:0] OFS_EXIT_CAP_HI    = 8'h30;
  localparam logic [7:0] OFS_TEXIT_CAP_LO   = 8'h34;
  localparam logic [7:0] OFS_TEXIT_CAP_HI   = 8'h38;
  localparam logic [7:0] OFS_ENTRY_CAP_LO   = 8'h3C;
  localparam logic [7:0] OFS_ENTRY_CAP_HI   = 8'h40;
  localparam logic [7:0] OFS_TENTRY_CAP_LO  = 8'h44;
  localparam logic [7:0] OFS_TENTRY_CAP_HI  = 8'h48;
  localparam logic [7:0] OFS_MISC_CAP       = 8'h4C;
  localparam logic [7:0] OFS_STATUS         = 8'h50;
  localparam logic [7:0] OFS_CMD            = 8'h54;
  // ==========================================================
  // Control vector bit positions
  localparam int unsigned EN_DBG     = 2;
  localparam int unsigned EN_LMGUEST = 9;
  localparam int unsigned EN_SYSMGMT = 10;
  localparam int unsigned EN_DUALOFF = 11;
  localparam int unsigned EN_PERF    = 13;
  localparam int unsigned EN_PAT     = 14;
  localparam int unsigned EN_EFER    = 15;
  localparam int unsigned EX_HOST64  = 9;
  localparam int unsigned MISC_LMSV  = 5;
  localparam int unsigned CMD_ENTRY  = 0;
  localparam int unsigned CMD_EXIT   = 1;
  // ==========================================================
  // Capability defaults: low word allowed-zero, high word allowed-one
  localparam logic [31:0] EXIT_DEF1  = 32'h0003_6DFF;
  localparam logic [31:0] ENTRY_DEF1 = 32'h0000_11FF;
  localparam logic [31:0] EXIT_ALLOW1  = 32'h007F_FFFF;
  localparam logic [31:0] ENTRY_ALLOW1 = 32'h0000_FFFF;
  localparam logic [31:0] EXIT_TRUE0  = 32'h0003_6DFB;
  localparam logic [31:0] ENTRY_TRUE0 = 32'h0000_11FB;
  localparam logic [31:0] MISC_VAL    = 32'h0000_0020;
  localparam logic [31:0] ZERO32      = 32'h0000_0000;
  localparam logic [3:0]  ALIGN_MASK  = 4'hF;
  // ==========================================================
  typedef enum logic [1:0] {
    VTM_ROOT  = 2'b00,
    VTM_GUEST = 2'b01
  } vtm_mode_e;
  typedef struct packed {
    logic [31:0] count;
    logic [63:0] base;
  } vtm_list_s;
  typedef struct packed {
    logic dbg;
    logic perf;
    logic pat;
    logic efer;
    logic sys_mgmt;
    logic dual_off;
    logic lm_guest;
  } vtm_load_s;
endpackage : vtm_pkg
`default_nettype wire

// ==== hw/vtm_list_check.sv ====
`default_nettype none
module vtm_list_check (
  // List descriptor
  input  wire vtm_pkg::vtm_list_s desc,
  // Verdict
  output logic                    active,
  output logic                    bad_align
);
  import vtm_pkg::*;
  // ==========================================================
  // Zero count skips the area and waives alignment
  assign active    = (desc.count != ZERO32);
  assign bad_align = active &&
                     ((desc.base[3:0] & ALIGN_MASK) != 4'h0);
endmodule : vtm_list_check
`default_nettype wire

// ==== hw/vtm_bank.sv ====
// Design decisions made here: the address map and register access over AHB-Lite.
`default_nettype none
module vtm_bank (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              clk_en,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [7:0]        haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Processor state
  input  wire logic              long_mode_enable_flag,
  input  wire logic              in_system_management_mode,
  output logic                   long_mode_active_flag,
  output logic                   host_64bit_mode,
  output logic                   virtualization_active,
  output vtm_pkg::vtm_load_s     entry_loads,
  output logic                   entry_done,
  output logic                   entry_failed,
  output logic                   exit_done
);
  import vtm_pkg::*;
  // ==========================================================
  // Bus address phase capture
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic [31:0] exit_ctl_r;
  logic [31:0] entry_control_vector_r;
  logic [31:0] entry_control_vector_nxt;
  vtm_list_s   exit_list_store_r;
  vtm_list_s   exit_list_load_r;
  vtm_list_s   entry_list_load_r;
  vtm_mode_e   mode_r;
  vtm_mode_e   mode_nxt;
  logic        lma_r;
  logic        lma_nxt;
  logic        host64_r;
  logic        guest_r;
  logic        done_r;
  logic        fail_r;
  logic        xdone_r;
  logic        last_fail_r;
  vtm_load_s   loads_r;
  logic [31:0] rdata_r;
  wire         acc   = hsel && hready && htrans[1];
  wire         rd_go = acc && !hwrite;
  wire         wr_go = wr_pend_r;
  wire         cmd_wr = wr_go && (wr_addr_r == OFS_CMD);
  wire         do_entry = cmd_wr && hwdata[CMD_ENTRY];
  wire         do_exit  = cmd_wr && hwdata[CMD_EXIT] && !hwdata[CMD_ENTRY];
  // ==========================================================
  // Reserved-bit checks against capability values
  wire exit_ok  = ((exit_ctl_r & EXIT_TRUE0) == EXIT_TRUE0) &&
                  ((exit_ctl_r & ~EXIT_ALLOW1) == ZERO32);
  wire entry_ok = ((entry_control_vector_r & ENTRY_TRUE0) == ENTRY_TRUE0) &&
                  ((entry_control_vector_r & ~ENTRY_ALLOW1) == ZERO32);
  // Software promise: bits 10 and 11 only from system management
  wire sysmgmt_ok = in_system_management_mode ||
                    (!entry_control_vector_r[EN_SYSMGMT] &&
                     !entry_control_vector_r[EN_DUALOFF]);
  // ==========================================================
  // List descriptor checks
  logic es_act, es_bad, el_act, el_bad, nl_act, nl_bad;
  vtm_list_check u_chk_exit_store (
    .desc      (exit_list_store_r),
    .active    (es_act),
    .bad_align (es_bad)
  );
  vtm_list_check u_chk_exit_load (
    .desc      (exit_list_load_r),
    .active    (el_act),
    .bad_align (el_bad)
  );
  vtm_list_check u_chk_entry_load (
    .desc      (entry_list_load_r),
    .active    (nl_act),
    .bad_align (nl_bad)
  );
  // Misaligned active lists also fail entry; idle lists never do
  wire lists_ok  = !es_bad && !el_bad && !nl_bad;
  wire entry_pass = exit_ok && entry_ok && sysmgmt_ok && lists_ok;
  // ==========================================================
  // Transition state
  always_comb begin
    mode_nxt = mode_r;
    lma_nxt  = lma_r;
    if (do_entry && entry_pass) begin
      mode_nxt = VTM_GUEST;
      lma_nxt  = entry_control_vector_r[EN_LMGUEST];
    end else if (do_exit && mode_r == VTM_GUEST) begin
      mode_nxt = VTM_ROOT;
      lma_nxt  = exit_ctl_r[EX_HOST64];
    end else if (mode_r == VTM_ROOT) begin
      lma_nxt  = long_mode_enable_flag;
    end
  end
  // Exit records guest long mode into entry bit 9
  always_comb begin
    entry_control_vector_nxt = entry_control_vector_r;
    if (wr_go && wr_addr_r == OFS_ENTRY_CTL) begin
      entry_control_vector_nxt = hwdata;
    end
    if (do_exit && mode_r == VTM_GUEST && MISC_VAL[MISC_LMSV]) begin
      entry_control_vector_nxt[EN_LMGUEST] = lma_r;
    end
  end
  // ==========================================================
  // Register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exit_ctl_r             <= EXIT_DEF1;
      entry_control_vector_r <= ENTRY_DEF1;
      exit_list_store_r      <= '0;
      exit_list_load_r       <= '0;
      entry_list_load_r      <= '0;
    end else if (clk_en) begin
      entry_control_vector_r <= entry_control_vector_nxt;
      if (wr_go) begin
        if (wr_addr_r == OFS_EXIT_CTL) begin
          exit_ctl_r <= hwdata;
        end else if (wr_addr_r == OFS_EXIT_ST_CNT) begin
          exit_list_store_r.count <= hwdata;
        end else if (wr_addr_r == OFS_EXIT_ST_LO) begin
          exit_list_store_r.base[31:0] <= hwdata;
        end else if (wr_addr_r == OFS_EXIT_ST_HI) begin
          exit_list_store_r.base[63:32] <= hwdata;
        end else if (wr_addr_r == OFS_EXIT_LD_CNT) begin
          exit_list_load_r.count <= hwdata;
        end else if (wr_addr_r == OFS_EXIT_LD_LO) begin
          exit_list_load_r.base[31:0] <= hwdata;
        end else if (wr_addr_r == OFS_EXIT_LD_HI) begin
          exit_list_load_r.base[63:32] <= hwdata;
        end else if (wr_addr_r == OFS_ENTRY_LD_CNT) begin
          entry_list_load_r.count <= hwdata;
        end else if (wr_addr_r == OFS_ENTRY_LD_LO) begin
          entry_list_load_r.base[31:0] <= hwdata;
        end else if (wr_addr_r == OFS_ENTRY_LD_HI) begin
          entry_list_load_r.base[63:32] <= hwdata;
        end
      end
    end
  end
  // ==========================================================
  // Bus phase and transition outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r   <= 1'b0;
      wr_addr_r   <= 8'h00;
      mode_r      <= VTM_ROOT;
      lma_r       <= 1'b0;
      host64_r    <= 1'b0;
      guest_r     <= 1'b0;
      done_r      <= 1'b0;
      fail_r      <= 1'b0;
      xdone_r     <= 1'b0;
      last_fail_r <= 1'b0;
      loads_r     <= '0;
    end else if (clk_en) begin
      wr_pend_r <= acc && hwrite;
      if (acc) begin
        wr_addr_r <= haddr;
      end
      mode_r  <= mode_nxt;
      guest_r <= (mode_nxt == VTM_GUEST);
      lma_r   <= lma_nxt;
      done_r  <= do_entry && entry_pass;
      fail_r  <= do_entry && !entry_pass;
      xdone_r <= do_exit && mode_r == VTM_GUEST;
      if (do_entry) begin
        last_fail_r <= !entry_pass;
      end
      if (do_exit && mode_r == VTM_GUEST) begin
        host64_r <= exit_ctl_r[EX_HOST64];
      end
      if (do_entry && entry_pass) begin
        loads_r.dbg      <= entry_control_vector_r[EN_DBG];
        loads_r.perf     <= entry_control_vector_r[EN_PERF];
        loads_r.pat      <= entry_control_vector_r[EN_PAT];
        loads_r.efer     <= entry_control_vector_r[EN_EFER];
        loads_r.sys_mgmt <= entry_control_vector_r[EN_SYSMGMT];
        loads_r.dual_off <= entry_control_vector_r[EN_DUALOFF];
        loads_r.lm_guest <= entry_control_vector_r[EN_LMGUEST];
      end
    end
  end
  // ==========================================================
  // Read decode; capabilities are constant
  logic [31:0] rd_mux;
  always_comb begin
    if (haddr == OFS_EXIT_CTL) rd_mux = exit_ctl_r;
    else if (haddr == OFS_ENTRY_CTL) rd_mux = entry_control_vector_r;
    else if (haddr == OFS_EXIT_ST_CNT) rd_mux = exit_list_store_r.count;
    else if (haddr == OFS_EXIT_ST_LO) rd_mux = exit_list_store_r.base[31:0];
    else if (haddr == OFS_EXIT_ST_HI) rd_mux = exit_list_store_r.base[63:32];
    else if (haddr == OFS_EXIT_LD_CNT) rd_mux = exit_list_load_r.count;
    else if (haddr == OFS_EXIT_LD_LO) rd_mux = exit_list_load_r.base[31:0];
    else if (haddr == OFS_EXIT_LD_HI) rd_mux = exit_list_load_r.base[63:32];
    else if (haddr == OFS_ENTRY_LD_CNT) rd_mux = entry_list_load_r.count;
    else if (haddr == OFS_ENTRY_LD_LO) rd_mux = entry_list_load_r.base[31:0];
    else if (haddr == OFS_ENTRY_LD_HI) rd_mux = entry_list_load_r.base[63:32];
    else if (haddr == OFS_EXIT_CAP_LO) rd_mux = EXIT_DEF1;
    else if (haddr == OFS_EXIT_CAP_HI) rd_mux = EXIT_ALLOW1;
    else if (haddr == OFS_TEXIT_CAP_LO) rd_mux = EXIT_TRUE0;
    else if (haddr == OFS_TEXIT_CAP_HI) rd_mux = EXIT_ALLOW1;
    else if (haddr == OFS_ENTRY_CAP_LO) rd_mux = ENTRY_DEF1;
    else if (haddr == OFS_ENTRY_CAP_HI) rd_mux = ENTRY_ALLOW1;
    else if (haddr == OFS_TENTRY_CAP_LO) rd_mux = ENTRY_TRUE0;
    else if (haddr == OFS_TENTRY_CAP_HI) rd_mux = ENTRY_ALLOW1;
    else if (haddr == OFS_MISC_CAP) rd_mux = MISC_VAL;
    else if (haddr == OFS_STATUS)
      rd_mux = {27'h0, last_fail_r, nl_act, el_act, es_act,
                mode_r == VTM_GUEST};
    else rd_mux = ZERO32;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_r <= 32'h0000_0000;
    end else if (clk_en && rd_go) begin
      rdata_r <= rd_mux;
    end
  end
  // ==========================================================
  // Outputs from flops except constant hreadyout and hresp; zero wait state, always OKAY
  assign hrdata                = rdata_r;
  assign hreadyout             = 1'b1;
  assign hresp                 = 1'b0;
  assign long_mode_active_flag = lma_r;
  assign host_64bit_mode       = host64_r;
  assign virtualization_active = guest_r;
  assign entry_loads           = loads_r;
  assign entry_done            = done_r;
  assign entry_failed          = fail_r;
  assign exit_done             = xdone_r;
  // ==========================================================
  // Checks
  property p_fail_bad;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && do_entry && !entry_ok) |=> entry_failed && !entry_done;
  endproperty
  a_fail_bad: assert property (p_fail_bad)
    else $error("entry with bad reserved bits not failed");
  property p_lma_track;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && mode_r == VTM_ROOT && !do_entry) |=>
      long_mode_active_flag == $past(long_mode_enable_flag);
  endproperty
  a_lma_track: assert property (p_lma_track)
    else $error("long mode active does not follow enable");
  property p_lm_entry;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && do_entry && entry_pass) |=>
      long_mode_active_flag == $past(entry_control_vector_r[EN_LMGUEST]);
  endproperty
  a_lm_entry: assert property (p_lm_entry)
    else $error("entry bit 9 not copied to long mode active");
  property p_exit64;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && do_exit && mode_r == VTM_GUEST) |=>
      host_64bit_mode == $past(exit_ctl_r[EX_HOST64]) && exit_done;
  endproperty
  a_exit64: assert property (p_exit64)
    else $error("exit bit 9 not applied");
  property p_save_lm;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && do_exit && mode_r == VTM_GUEST) |=>
      entry_control_vector_r[EN_LMGUEST] == $past(lma_r);
  endproperty
  a_save_lm: assert property (p_save_lm)
    else $error("exit did not record long mode active");
  property p_loads;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && do_entry && entry_pass) |=>
      entry_loads.dbg == $past(entry_control_vector_r[EN_DBG]) &&
      entry_loads.efer == $past(entry_control_vector_r[EN_EFER]);
  endproperty
  a_loads: assert property (p_loads)
    else $error("entry load selects not captured");
  property p_sysmgmt;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && do_entry && !in_system_management_mode &&
     entry_control_vector_r[EN_SYSMGMT]) |=> entry_failed;
  endproperty
  a_sysmgmt: assert property (p_sysmgmt)
    else $error("system management entry from outside accepted");
  property p_guest;
    @(posedge hclk) disable iff (!hresetn)
    entry_done |-> virtualization_active;
  endproperty
  a_guest: assert property (p_guest)
    else $error("entry done without guest mode");
  property p_dual_off;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && do_entry && !in_system_management_mode &&
     entry_control_vector_r[EN_DUALOFF]) |=> entry_failed;
  endproperty
  a_dual_off: assert property (p_dual_off)
    else $error("default interrupt handling entry from outside accepted");
  property p_perf_pat;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && do_entry && entry_pass) |=>
      entry_loads.perf == $past(entry_control_vector_r[EN_PERF]) &&
      entry_loads.pat == $past(entry_control_vector_r[EN_PAT]);
  endproperty
  a_perf_pat: assert property (p_perf_pat)
    else $error("perf or attribute load select not captured");
  property p_align;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && do_entry && nl_act &&
     (entry_list_load_r.base[3:0] & ALIGN_MASK) != 4'h0) |=> entry_failed;
  endproperty
  a_align: assert property (p_align)
    else $error("misaligned entry list accepted");
  property p_zero_skip;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && do_entry && exit_ok && entry_ok && sysmgmt_ok &&
     !es_act && !el_act && !nl_act) |=> entry_done;
  endproperty
  a_zero_skip: assert property (p_zero_skip)
    else $error("entry with idle lists not taken");
endmodule : vtm_bank
`default_nettype wire

// ==== dv/vtm_host_model.sv ====
`default_nettype none
module vtm_host_model (
  // Bus clock
  input  wire logic        hclk,
  // AHB-Lite master side
  output logic             hsel,
  output logic [7:0]       haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import vtm_pkg::*;
  // ==========================================================
  // Idle bus from time zero
  initial begin
    hsel   = 1'b0;
    haddr  = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // ==========================================================
  // Single word transfer, entered on a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd,
                      output logic [31:0] rd, output bit ok);
    int n;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    ok = (hready === 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 80);
    rd = hrdata;
    ok = ok && (hready === 1'b1);
  endtask : xfer
  // ==========================================================
  // Counts kept small; the same misaligned base serves the failing and the zero-count case
  task automatic set_list(input logic [7:0] a, input logic [31:0] cnt,
                          input logic [63:0] base, output bit ok);
    logic [31:0] r;
    bit          o1, o2, o3;
    xfer(1'b1, a, cnt, r, o1);
    xfer(1'b1, a + 8'h04, base[31:0], r, o2);
    xfer(1'b1, a + 8'h08, base[63:32], r, o3);
    ok = o1 && o2 && o3;
  endtask : set_list
endmodule : vtm_host_model
`default_nettype wire

// ==== dv/test_vm_transition_msr_lists.sv ====
`default_nettype none
module test_vm_transition_msr_lists;
  timeunit 1ns;
  timeprecision 1ns;
  import vtm_pkg::*;
  // ==========================================================
  // Signals
  logic        hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp;
  logic        long_mode_enable_flag, in_system_management_mode;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  logic        long_mode_active_flag, host_64bit_mode;
  logic        virtualization_active, entry_done, entry_failed, exit_done;
  vtm_load_s   entry_loads;
  int          err_count, checks;
  wire logic [31:0] st_flags = {29'h0, host_64bit_mode,
                                virtualization_active, long_mode_active_flag};
  // ==========================================================
  // Instances
  vtm_bank DUT (
    .hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .long_mode_enable_flag, .in_system_management_mode,
    .long_mode_active_flag, .host_64bit_mode, .virtualization_active,
    .entry_loads, .entry_done, .entry_failed, .exit_done
  );
  vtm_host_model host (
    .hclk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata
  );
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // ==========================================================
  // Helpers
  task automatic finish_test;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic hang;
    err_count++;
    finish_test();
  endtask : hang
  task automatic ck(input string nm, input logic [31:0] exp,
                    input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask : ck
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bit          ok;
    host.xfer(1'b1, a, d, r, ok);
    if (!ok) hang();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bit ok;
    host.xfer(1'b0, a, 32'h0, d, ok);
    if (!ok) hang();
  endtask : rd
  // Pulses gathered over a fixed window: {exit, failed, done}
  task automatic cmd(input logic [31:0] c, output logic [31:0] s);
    wr(OFS_CMD, c);
    s = 32'h0;
    repeat (6) begin
      @(posedge hclk);
      s[2:0] = s[2:0] | {exit_done, entry_failed, entry_done};
    end
  endtask : cmd
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    logic [31:0] v;
    rd(OFS_EXIT_CTL, v);
    ck("exit_ctl", 32'h0003_6DFF, v);
    rd(OFS_ENTRY_CTL, v);
    ck("entry_ctl", 32'h0000_11FF, v);
    wr(OFS_EXIT_CAP_LO, 32'h0);
    rd(OFS_EXIT_CAP_LO, v);
    ck("exit_cap", 32'h0003_6DFF, v & 32'h0003_6DFF);
    wr(OFS_ENTRY_CAP_LO, 32'h0);
    rd(OFS_ENTRY_CAP_LO, v);
    ck("entry_cap", 32'h0000_11FF, v & 32'h0000_11FF);
    rd(OFS_MISC_CAP, v);
    ck("misc_b5", 32'h0000_0020, v & 32'h0000_0020);
    rd(8'h60, v);
    ck("unmapped", 32'h0, v);
    ck("hresp", 32'h0, 32'(hresp));
    for (int a = 8; a <= 40; a += 4) begin
      rd(8'(a), v);
      ck("list_rst", 32'h0, v);
      wr(8'(a), 32'hC0DE_0000 | 32'(a));
      rd(8'(a), v);
      ck("list_rw", 32'hC0DE_0000 | 32'(a), v);
      wr(8'(a), 32'h0);
    end
  endtask : t_regs
  task automatic t_lma;
    long_mode_enable_flag <= 1'b1;
    repeat (3) @(posedge hclk);
    ck("lma_on", 32'h1, st_flags & 32'h1);
    long_mode_enable_flag <= 1'b0;
    repeat (3) @(posedge hclk);
    ck("lma_off", 32'h0, st_flags & 32'h1);
    clk_en                <= 1'b0;
    long_mode_enable_flag <= 1'b1;
    repeat (3) @(posedge hclk);
    ck("lma_frozen", 32'h0, st_flags & 32'h1);
    clk_en                <= 1'b1;
    long_mode_enable_flag <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask : t_lma
  task automatic t_trans;
    logic [31:0] s, v;
    wr(OFS_ENTRY_CTL, 32'h0000_F3FF);
    cmd(32'h1, s);
    ck("entry1", 32'h1, s);
    ck("loads1", 32'h79, {25'h0, entry_loads});
    ck("flags1", 32'h3, st_flags);
    wr(OFS_ENTRY_CTL, 32'h0000_F1FF);
    wr(OFS_EXIT_CTL, 32'h0003_6DFF);
    cmd(32'h2, s);
    ck("exit1", 32'h4, s);
    ck("flags2", 32'h0, st_flags);
    rd(OFS_ENTRY_CTL, v);
    ck("lma_saved1", 32'h0000_F3FF, v);
    wr(OFS_ENTRY_CTL, 32'h0000_F1FB);
    cmd(32'h1, s);
    ck("entry2", 32'h1, s);
    ck("loads2", 32'h38, {25'h0, entry_loads});
    ck("flags3", 32'h2, st_flags);
    wr(OFS_ENTRY_CTL, 32'h0000_F3FB);
    wr(OFS_EXIT_CTL, 32'h0003_6FFF);
    cmd(32'h2, s);
    ck("exit2", 32'h4, s);
    ck("host64", 32'h4, st_flags & 32'h6);
    rd(OFS_ENTRY_CTL, v);
    ck("lma_saved0", 32'h0000_F1FB, v);
    wr(OFS_EXIT_CTL, 32'h0003_6DFF);
    wr(OFS_ENTRY_CTL, 32'h0000_11FF);
  endtask : t_trans
  task automatic t_fail;
    logic [7:0]  fa [5] = '{OFS_ENTRY_CTL, OFS_ENTRY_CTL, OFS_EXIT_CTL,
                            OFS_ENTRY_CTL, OFS_ENTRY_CTL};
    logic [31:0] fv [5] = '{32'h0000_11FE, 32'h0001_11FF, 32'h0003_6DFE,
                            32'h0000_15FF, 32'h0000_19FF};
    logic [7:0]  la [3] = '{OFS_EXIT_ST_CNT, OFS_EXIT_LD_CNT,
                            OFS_ENTRY_LD_CNT};
    logic [31:0] s, v;
    bit          ok;
    for (int i = 0; i < 5; i++) begin
      wr(fa[i], fv[i]);
      cmd(32'h1, s);
      ck("bad_ctl", 32'h2, 32'({virtualization_active, s[2:0]}));
      wr(OFS_EXIT_CTL, 32'h0003_6DFF);
      wr(OFS_ENTRY_CTL, 32'h0000_11FF);
    end
    // Same misaligned base both ways: only the count decides
    for (int k = 0; k < 3; k++) begin
      host.set_list(la[k], 32'h1, 64'h0000_0000_0000_1008, ok);
      if (!ok) hang();
      cmd(32'h1, s);
      ck("misalign", 32'h2, 32'({virtualization_active, s[2:0]}));
      rd(OFS_STATUS, v);
      ck("status", 32'h10 | (32'h2 << k), v);
      host.set_list(la[k], 32'h0, 64'h0000_0000_0000_1008, ok);
      if (!ok) hang();
      cmd(32'h1, s);
      ck("zero_cnt", 32'h1, s);
      cmd(32'h2, s);
      ck("exit3", 32'h4, s);
    end
  endtask : t_fail
  task automatic t_sysmgmt;
    logic [31:0] s;
    in_system_management_mode <= 1'b1;
    wr(OFS_ENTRY_CTL, 32'h0000_1DFF);
    cmd(32'h1, s);
    ck("sysmgmt_entry", 32'h1, s);
    ck("sysmgmt_loads", 32'h6, {25'h0, entry_loads} & 32'h6);
    cmd(32'h2, s);
    ck("sysmgmt_exit", 32'h4, s);
    in_system_management_mode <= 1'b0;
    wr(OFS_ENTRY_CTL, 32'h0000_11FF);
  endtask : t_sysmgmt
  // ==========================================================
  // Main sequence
  initial begin
    hresetn = 1'b0;
    clk_en = 1'b1;
    long_mode_enable_flag = 1'b0;
    in_system_management_mode = 1'b0;
    err_count = 0;
    checks = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_lma();
    t_trans();
    t_fail();
    t_sysmgmt();
    finish_test();
  end
endmodule : test_vm_transition_msr_lists
`default_nettype wire
